/* File: irq_timing_measurement_control_config_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module irq_timing_measurement_control_config_tb_top
  import irqtm_pkg::*;
;
  logic clk, rst_b, ack_rd, pin, oe_b, lvl;
  irqtm_reg_req_type req;
  irqtm_cond_type cond;
  logic [2:0] act_ax, inact_ax, rate_sel, wake_sel, bw_sel;
  logic [7:0] rdata, rv;
  logic [12:0] rate_hz;
  logic [14:0] wake_ms;
  logic [11:0] bw_hz;
  logic external_clock_enable, ext_trg, ovr, lown, act_det, inact_det, act_f, inact_f, wake;
  int failures, checks_done;

  irqtm_top i_irqtm_top (.sys_clk_in(clk), .rst_b_in(rst_b), .reg_req_in(req),
    .cond_in(cond), .axis_activity_enable_in(act_ax), .axis_inactivity_enable_in(inact_ax),
    .status_read_in(ack_rd), .reg_rdata_out(rdata), .irq_pin_b_out(pin),
    .irq_pin_b_oe_b_out(oe_b), .sample_rate_sel_out(rate_sel), .sample_rate_hz_out(rate_hz),
    .wake_interval_sel_out(wake_sel), .wake_period_ms_out(wake_ms),
    .external_clock_enable_out(external_clock_enable), .external_trigger_enable_out(ext_trg),
    .overrange_disable_out(ovr), .low_noise_out(lown), .bandwidth_sel_out(bw_sel),
    .bandwidth_hz_out(bw_hz), .activity_detect_enable_out(act_det),
    .inactivity_detect_enable_out(inact_det), .activity_flag_out(act_f),
    .inactivity_flag_out(inact_f), .wake_mode_enter_out(wake));

  irqtm_host_model i_irqtm_host_model (.sys_clk_in(clk), .rdata_in(rdata), .pin_in(pin),
    .pin_oe_b_in(oe_b), .reg_req_out(req), .pin_level_out(lvl));

  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  task automatic end_of_test;
    if (failures == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    i_irqtm_host_model.access(1'h1, a, d, rv);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string what);
    i_irqtm_host_model.access(1'h0, a, 8'h00, rv);
    check({8'h00, rv}, {8'h00, exp}, what);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Condition bits held for one sampling edge
  task automatic pulse(input logic [3:0] c);
    @(negedge clk);
    cond = irqtm_cond_type'(c);
    @(negedge clk);
    cond = '0;
  endtask

  task automatic ack;
    @(negedge clk);
    ack_rd = 1'h1;
    @(negedge clk);
    ack_rd = 1'h0;
  endtask

  task automatic t_reset;
    check({15'h0, oe_b}, 16'h0001, "float at reset");
    rchk(8'h3C, 8'h00, "route reset");
    rchk(8'h3D, 8'h00, "timing reset");
    rchk(8'h3E, 8'h00, "measurement_control reset");
    wreg(8'h3F, 8'hA5);
    rchk(8'h3F, 8'h00, "unmapped");
    wreg(8'h3C, 8'hFF);
    rchk(8'h3C, 8'hF1, "reserved bits");
  endtask

  task automatic t_pins;
    logic [7:0] m [4];
    logic p;
    m = '{8'h40, 8'h20, 8'h10, 8'h01};
    for (int pi = 0; pi < 2; pi++) begin
      p = pi[0];
      for (int k = 0; k < 4; k++) begin
        wreg(8'h3C, {p, 7'h00} | m[k]);
        cyc(1);
        check({15'h0, lvl}, {15'h0, p}, "idle level");
        if (k == 0 || k == 3) begin
          cond = irqtm_cond_type'(4'h8 >> k);
          cyc(2);
          check({15'h0, lvl}, {15'h0, ~p}, "level on");
          cond = '0;
          cyc(2);
        end else begin
          pulse(4'h8 >> k);
          cyc(1);
          check({15'h0, lvl}, {15'h0, ~p}, "event on");
          ack();
          cyc(1);
        end
        check({15'h0, lvl}, {15'h0, p}, "pin off");
      end
    end
    wreg(8'h3C, 8'h71);
    cond.sample_ready = 1'h1;
    cyc(2);
    check({15'h0, lvl}, 16'h0001, "or of routes");
    wreg(8'h3C, 8'h40);
    cyc(2);
    check({15'h0, lvl}, 16'h0000, "unrouted cond");
    wreg(8'h3C, 8'h80);
    cyc(2);
    check({15'h0, oe_b}, 16'h0001, "float");
    cond = '0;
  endtask

  task automatic t_timing;
    logic [12:0] rt [8];
    logic [14:0] wt [8];
    logic [7:0] v;
    rt = '{13'h140, 13'h280, 13'h500, 13'hA00, 13'h1400, 13'h0, 13'h0, 13'h0};
    wt = '{15'h41, 15'h82, 15'h104, 15'h280, 15'hA00, 15'h1400, 15'h2800, 15'h7800};
    for (int i = 0; i < 8; i++) begin
      v = {i[2:0], ~i[2:0], i[1:0]};
      wreg(8'h3D, v);
      cyc(1);
      check({10'h0, rate_sel, wake_sel}, {10'h0, v[7:2]}, "codes");
      check({3'h0, rate_hz}, {3'h0, rt[i]}, "rate hz");
      check({1'b0, wake_ms}, {1'b0, wt[~i[2:0]]}, "wake ms");
      check({14'h0, external_clock_enable, ext_trg}, {14'h0, i[1:0]}, "ext");
      rchk(8'h3D, v, "timing rd");
    end
  endtask

  task automatic t_measurement_control;
    logic [11:0] bt [8];
    logic [7:0] v;
    bt = '{12'hA0, 12'h140, 12'h280, 12'h500, 12'hA00, 12'h0, 12'h0, 12'h0};
    for (int i = 0; i < 8; i++) begin
      v = {i[0], 3'h0, i[1], i[2:0]};
      wreg(8'h3E, v);
      cyc(1);
      check({11'h0, ovr, lown, bw_sel}, {11'h0, v[7], v[3:0]}, "meas");
      check({4'h0, bw_hz}, {4'h0, bt[i]}, "bw hz");
      rchk(8'h3E, v, "meas rd");
    end
  endtask

  task automatic t_seq;
    act_ax = 3'h7;
    inact_ax = 3'h7;
    wreg(8'h3E, 8'h50);
    cyc(1);
    check({14'h0, act_det, inact_det}, 16'h0002, "linked start");
    pulse(4'h4);
    check({13'h0, act_f, act_det, inact_det}, 16'h0005, "linked act");
    pulse(4'h2);
    check({12'h0, inact_f, wake, act_det, inact_det}, 16'h000E, "autosleep");
    cyc(3);
    check({13'h0, act_f, inact_f, wake}, 16'h0006, "held");
    ack();
    check({14'h0, act_f, inact_f}, 16'h0000, "ack");
    act_ax = 3'h3;
    cyc(2);
    check({14'h0, act_det, inact_det}, 16'h0003, "fallback");
    pulse(4'h2);
    check({14'h0, inact_f, wake}, 16'h0002, "no sleep");
    ack();
    act_ax = 3'h7;
    wreg(8'h3E, 8'h60);
    cyc(1);
    pulse(4'h4);
    check({13'h0, act_f, act_det, inact_det}, 16'h0005, "looped act");
    cyc(1);
    check({15'h0, act_f}, 16'h0000, "self ack");
    pulse(4'h2);
    check({14'h0, inact_f, wake}, 16'h0003, "looped sleep");
    cyc(1);
    check({15'h0, inact_f}, 16'h0000, "self ack 2");
    wreg(8'h3E, 8'h40);
    cyc(1);
    check({14'h0, act_det, inact_det}, 16'h0003, "default both");
    pulse(4'h2);
    check({14'h0, inact_f, wake}, 16'h0002, "sleep ignored");
    pulse(4'h4);
    cyc(2);
    check({14'h0, act_f, inact_f}, 16'h0003, "sticky");
    ack();
    check({14'h0, act_f, inact_f}, 16'h0000, "host ack");
  endtask

  // Reset in mid-run after the registers hold values
  task automatic t_rereset;
    wreg(8'h3C, 8'h91);
    @(negedge clk);
    rst_b = 1'h0;
    cyc(2);
    rst_b = 1'h1;
    check({15'h0, oe_b}, 16'h0001, "float after reset");
    rchk(8'h3C, 8'h00, "route cleared");
    rchk(8'h3D, 8'h00, "timing cleared");
    rchk(8'h3E, 8'h00, "measurement_control cleared");
  endtask

  initial begin
    rst_b = 1'h0;
    ack_rd = 1'h0;
    cond = '0;
    act_ax = 3'h0;
    inact_ax = 3'h0;
    failures = 0;
    checks_done = 0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst_b = 1'h1;
    t_reset();
    t_pins();
    t_timing();
    t_measurement_control();
    t_seq();
    t_rereset();
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    $display("unexpected at %0t: run too long", $time);
    end_of_test();
  end
endmodule
`default_nettype wire

/* File: irqtm_cfg.svh */
// What this block does
// RL1 - Routing bit 7 makes pin B active low
// RL2 - Routing bit 6 puts awake on pin B
// RL3 - Routing bit 5 puts activity on pin B
// RL4 - Routing bit 4 puts inactivity on pin B
// RL5 - Routing bit 0 puts sample ready on pin B
// RL6 - Rate field 7:5 selects 320 to 5120 Hz
// RL7 - Wake field 4:2 selects 65 to 30720 ms
// RL8 - Timing bits enable external clock and trigger
// RL9 - Autosleep enters wake-up mode on inactivity
// RL10 - Autosleep ignored unless linked or looped
// RL11 - Mode 0 runs both detectors, host acknowledges
// RL12 - Linked mode alternates detectors, host acknowledges
// RL13 - Looped mode alternates detectors, acknowledges internally
// RL14 - Linked or looped needs all axis enables
// RL15 - Measurement bit 3 selects low noise
// RL16 - Bandwidth field 2:0 selects 160 to 2560 Hz
// RL17 - All three registers clear to zero
// RL18 - Routed conditions are ORed onto the pin
// RL19 - Pin floats when nothing is routed
// RL20 - Reserved bits read zero, writes ignored
`ifndef IRQTM_CFG_SVH
`define IRQTM_CFG_SVH

`define IRQTM_ADDR_ROUTE 8'h3C
`define IRQTM_ADDR_TIMING 8'h3D
`define IRQTM_ADDR_MEASUREMENT_CONTROL 8'h3E
`define IRQTM_RESET_VAL 8'h00
`define IRQTM_ROUTE_WMASK 8'hF1

`define IRQTM_ROUTE_POL 7
`define IRQTM_ROUTE_AWAKE 6
`define IRQTM_ROUTE_ACT 5
`define IRQTM_ROUTE_INACT 4
`define IRQTM_ROUTE_READY 0

`define IRQTM_RATE_MSB 7
`define IRQTM_RATE_LSB 5
`define IRQTM_WAKE_MSB 4
`define IRQTM_WAKE_LSB 2
`define IRQTM_EXTERNAL_CLOCK_ENABLE 1
`define IRQTM_EXT_TRIG 0

`define IRQTM_OVR_DIS 7
`define IRQTM_AUTOSLEEP 6
`define IRQTM_SEQ_MSB 5
`define IRQTM_SEQ_LSB 4
`define IRQTM_LOW_NOISE 3
`define IRQTM_BW_MSB 2
`define IRQTM_BW_LSB 0

`define IRQTM_SEQ_DEFAULT 2'h0
`define IRQTM_SEQ_LINKED 2'h1
`define IRQTM_SEQ_LOOPED 2'h2

`define IRQTM_RATE_HZ_0 13'h140
`define IRQTM_RATE_HZ_1 13'h280
`define IRQTM_RATE_HZ_2 13'h500
`define IRQTM_RATE_HZ_3 13'hA00
`define IRQTM_RATE_HZ_4 13'h1400

`define IRQTM_BW_HZ_0 12'hA0
`define IRQTM_BW_HZ_1 12'h140
`define IRQTM_BW_HZ_2 12'h280
`define IRQTM_BW_HZ_3 12'h500
`define IRQTM_BW_HZ_4 12'hA00

`define IRQTM_WAKE_MS_0 15'h41
`define IRQTM_WAKE_MS_1 15'h82
`define IRQTM_WAKE_MS_2 15'h104
`define IRQTM_WAKE_MS_3 15'h280
`define IRQTM_WAKE_MS_4 15'hA00
`define IRQTM_WAKE_MS_5 15'h1400
`define IRQTM_WAKE_MS_6 15'h2800
`define IRQTM_WAKE_MS_7 15'h7800

`endif

/* File: irqtm_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module irqtm_host_model
  import irqtm_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic [7:0] rdata_in,
  input wire logic pin_in,
  input wire logic pin_oe_b_in,
  output var irqtm_reg_req_type reg_req_out,
  output logic pin_level_out
);
  logic last_r = 1'h0;
  initial begin
    reg_req_out = '0;
  end
  // Released pin shows the inverse of its last driven level
  always @(pin_in or pin_oe_b_in) begin
    if (!pin_oe_b_in) begin
      last_r = pin_in;
    end
  end
  assign pin_level_out = pin_oe_b_in ? ~last_r : pin_in;
  // Strobe held across exactly one sampling edge
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
                        output logic [7:0] rdata);
    @(negedge sys_clk_in);
    reg_req_out = {wr, ~wr, addr, wdata};
    @(negedge sys_clk_in);
    reg_req_out = '0;
    rdata = rdata_in;
  endtask
endmodule
`default_nettype wire

/* File: irqtm_pin_drv.sv */
`timescale 1ns/1ps
`default_nettype none
`include "irqtm_cfg.svh"

module irqtm_pin_drv
  import irqtm_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic [7:0] route_in,
  input wire irqtm_cond_type cond_in,
  output logic pin_out,
  output logic pin_oe_b_out
);

  logic hit;
  logic any_route;

  assign hit = (route_in[`IRQTM_ROUTE_AWAKE] & cond_in.awake)              // see RL2
             | (route_in[`IRQTM_ROUTE_ACT] & cond_in.activity)             // see RL3
             | (route_in[`IRQTM_ROUTE_INACT] & cond_in.inactivity)         // see RL4
             | (route_in[`IRQTM_ROUTE_READY] & cond_in.sample_ready);      // see RL5 RL18
  assign any_route = route_in[`IRQTM_ROUTE_AWAKE] | route_in[`IRQTM_ROUTE_ACT]
                   | route_in[`IRQTM_ROUTE_INACT] | route_in[`IRQTM_ROUTE_READY];

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pin_out <= 1'h0;
      pin_oe_b_out <= 1'h1;
    end else begin
      pin_out <= hit ^ route_in[`IRQTM_ROUTE_POL];  // see RL1
      pin_oe_b_out <= ~any_route;  // see RL19
    end
  end

  property p_pin_level;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      !pin_oe_b_out |-> pin_out == ($past(hit) ^ $past(route_in[`IRQTM_ROUTE_POL]));
  endproperty
  a_pin_level: assert property (p_pin_level) else $error("pin level wrong"); // see RL1

  property p_pin_float;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      !any_route |=> pin_oe_b_out;
  endproperty
  a_pin_float: assert property (p_pin_float) else $error("pin driven unrouted"); // see RL19

  property p_pin_ready;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      route_in[`IRQTM_ROUTE_READY] && cond_in.sample_ready
      |=> !pin_oe_b_out && (pin_out != $past(route_in[`IRQTM_ROUTE_POL]));
  endproperty
  a_pin_ready: assert property (p_pin_ready) else $error("ready not on pin"); // see RL5

  property p_pin_awake;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      route_in[`IRQTM_ROUTE_AWAKE] && cond_in.awake
      |=> pin_out != $past(route_in[`IRQTM_ROUTE_POL]);
  endproperty
  a_pin_awake: assert property (p_pin_awake) else $error("awake not on pin"); // see RL2

  c_pin_low_active: cover property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    route_in[`IRQTM_ROUTE_POL] && hit ##1 !pin_out);

endmodule
`default_nettype wire

/* File: irqtm_pkg.sv */
package irqtm_pkg;

  typedef struct packed {
    logic awake;
    logic activity;
    logic inactivity;
    logic sample_ready;
  } irqtm_cond_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } irqtm_reg_req_type;

  typedef enum logic [1:0] {
    IRQTM_WATCH_ACT = 2'h1,
    IRQTM_WATCH_INACT = 2'h2
  } irqtm_seq_state_type;

endpackage

/* File: irqtm_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "irqtm_cfg.svh"

module irqtm_top
  import irqtm_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire irqtm_reg_req_type reg_req_in,
  input wire irqtm_cond_type cond_in,
  input wire logic [2:0] axis_activity_enable_in,
  input wire logic [2:0] axis_inactivity_enable_in,
  input wire logic status_read_in,
  output logic [7:0] reg_rdata_out,
  output logic irq_pin_b_out,
  output logic irq_pin_b_oe_b_out,
  output logic [2:0] sample_rate_sel_out,
  output logic [12:0] sample_rate_hz_out,
  output logic [2:0] wake_interval_sel_out,
  output logic [14:0] wake_period_ms_out,
  output logic external_clock_enable_out,
  output logic external_trigger_enable_out,
  output logic overrange_disable_out,
  output logic low_noise_out,
  output logic [2:0] bandwidth_sel_out,
  output logic [11:0] bandwidth_hz_out,
  output logic activity_detect_enable_out,
  output logic inactivity_detect_enable_out,
  output logic activity_flag_out,
  output logic inactivity_flag_out,
  output logic wake_mode_enter_out
);

  logic [7:0] route_r;
  logic [7:0] timing_r;
  logic [7:0] measurement_control_r;
  logic [7:0] rdata_nxt;
  logic [12:0] rate_hz_r;
  logic [11:0] bw_hz_r;
  logic [14:0] wake_ms_r;
  logic [1:0] seq_field;
  logic [1:0] seq_mode;
  logic sequenced;
  logic looped;
  irqtm_seq_state_type state_r;
  irqtm_seq_state_type state_nxt;
  logic act_en_r;
  logic inact_en_r;
  logic act_flag_r;
  logic inact_flag_r;
  logic wake_enter_r;
  logic act_hit;
  logic inact_hit;
  irqtm_cond_type pin_cond;

  // Register writes; reserved routing bits never store
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      route_r <= `IRQTM_RESET_VAL;  // see RL17
      timing_r <= `IRQTM_RESET_VAL;
      measurement_control_r <= `IRQTM_RESET_VAL;
    end else if (reg_req_in.wr) begin
      unique case (reg_req_in.addr)
        `IRQTM_ADDR_ROUTE: route_r <= reg_req_in.wdata & `IRQTM_ROUTE_WMASK;  // see RL20
        `IRQTM_ADDR_TIMING: timing_r <= reg_req_in.wdata;
        `IRQTM_ADDR_MEASUREMENT_CONTROL: measurement_control_r <= reg_req_in.wdata;
        default: ;
      endcase
    end
  end

  always_comb begin
    rdata_nxt = 8'h00;
    unique case (reg_req_in.addr)
      `IRQTM_ADDR_ROUTE: rdata_nxt = route_r;
      `IRQTM_ADDR_TIMING: rdata_nxt = timing_r;
      `IRQTM_ADDR_MEASUREMENT_CONTROL: rdata_nxt = measurement_control_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  // Read data one cycle after the read strobe, held until the next read
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_req_in.rd) begin
      reg_rdata_out <= rdata_nxt;
    end
  end

  // Decoded rate, interval and corner; reserved codes give zero
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rate_hz_r <= 13'h0;
      bw_hz_r <= 12'h0;
      wake_ms_r <= 15'h0;
    end else begin
      unique case (timing_r[`IRQTM_RATE_MSB:`IRQTM_RATE_LSB])  // see RL6
        3'h0: rate_hz_r <= `IRQTM_RATE_HZ_0;
        3'h1: rate_hz_r <= `IRQTM_RATE_HZ_1;
        3'h2: rate_hz_r <= `IRQTM_RATE_HZ_2;
        3'h3: rate_hz_r <= `IRQTM_RATE_HZ_3;
        3'h4: rate_hz_r <= `IRQTM_RATE_HZ_4;
        default: rate_hz_r <= 13'h0;
      endcase
      unique case (measurement_control_r[`IRQTM_BW_MSB:`IRQTM_BW_LSB])  // see RL16
        3'h0: bw_hz_r <= `IRQTM_BW_HZ_0;
        3'h1: bw_hz_r <= `IRQTM_BW_HZ_1;
        3'h2: bw_hz_r <= `IRQTM_BW_HZ_2;
        3'h3: bw_hz_r <= `IRQTM_BW_HZ_3;
        3'h4: bw_hz_r <= `IRQTM_BW_HZ_4;
        default: bw_hz_r <= 12'h0;
      endcase
      unique case (timing_r[`IRQTM_WAKE_MSB:`IRQTM_WAKE_LSB])  // see RL7
        3'h0: wake_ms_r <= `IRQTM_WAKE_MS_0;
        3'h1: wake_ms_r <= `IRQTM_WAKE_MS_1;
        3'h2: wake_ms_r <= `IRQTM_WAKE_MS_2;
        3'h3: wake_ms_r <= `IRQTM_WAKE_MS_3;
        3'h4: wake_ms_r <= `IRQTM_WAKE_MS_4;
        3'h5: wake_ms_r <= `IRQTM_WAKE_MS_5;
        3'h6: wake_ms_r <= `IRQTM_WAKE_MS_6;
        3'h7: wake_ms_r <= `IRQTM_WAKE_MS_7;
      endcase
    end
  end

  // Sequencing falls back to concurrent without every axis enabled
  assign seq_field = measurement_control_r[`IRQTM_SEQ_MSB:`IRQTM_SEQ_LSB];
  assign sequenced = ((seq_field == `IRQTM_SEQ_LINKED) || (seq_field == `IRQTM_SEQ_LOOPED))
                   && (&axis_activity_enable_in) && (&axis_inactivity_enable_in);  // see RL14
  assign seq_mode = sequenced ? seq_field : `IRQTM_SEQ_DEFAULT;
  assign looped = (seq_mode == `IRQTM_SEQ_LOOPED);
  assign act_hit = cond_in.activity & act_en_r;
  assign inact_hit = cond_in.inactivity & inact_en_r;

  always_comb begin
    state_nxt = state_r;
    if (!sequenced) begin
      state_nxt = IRQTM_WATCH_ACT;
    end else begin
      unique case (state_r)
        IRQTM_WATCH_ACT: if (act_hit) state_nxt = IRQTM_WATCH_INACT;  // see RL12 RL13
        IRQTM_WATCH_INACT: if (inact_hit) state_nxt = IRQTM_WATCH_ACT;
        default: state_nxt = IRQTM_WATCH_ACT;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_r <= IRQTM_WATCH_ACT;
      act_en_r <= 1'h1;
      inact_en_r <= 1'h1;
    end else begin
      state_r <= state_nxt;
      act_en_r <= !sequenced || (state_nxt == IRQTM_WATCH_ACT);  // see RL11 RL12
      inact_en_r <= !sequenced || (state_nxt == IRQTM_WATCH_INACT);
    end
  end

  // Sticky flags, self-cleared each cycle in looped mode; a new event beats the clear
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      act_flag_r <= 1'h0;
      inact_flag_r <= 1'h0;
    end else begin
      if (act_hit) begin
        act_flag_r <= 1'h1;
      end else if (looped || status_read_in) begin
        act_flag_r <= 1'h0;  // see RL11 RL12 RL13
      end
      if (inact_hit) begin
        inact_flag_r <= 1'h1;
      end else if (looped || status_read_in) begin
        inact_flag_r <= 1'h0;  // see RL11 RL12 RL13
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wake_enter_r <= 1'h0;
    end else begin
      wake_enter_r <= measurement_control_r[`IRQTM_AUTOSLEEP] && sequenced && inact_hit;  // see RL9 RL10
    end
  end

  assign pin_cond.awake = cond_in.awake;
  assign pin_cond.activity = act_flag_r;
  assign pin_cond.inactivity = inact_flag_r;
  assign pin_cond.sample_ready = cond_in.sample_ready;

  irqtm_pin_drv u_pin_b (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .route_in(route_r),
    .cond_in(pin_cond),
    .pin_out(irq_pin_b_out),
    .pin_oe_b_out(irq_pin_b_oe_b_out)
  );

  assign sample_rate_sel_out = timing_r[`IRQTM_RATE_MSB:`IRQTM_RATE_LSB];
  assign sample_rate_hz_out = rate_hz_r;
  assign wake_interval_sel_out = timing_r[`IRQTM_WAKE_MSB:`IRQTM_WAKE_LSB];
  assign wake_period_ms_out = wake_ms_r;
  assign external_clock_enable_out = timing_r[`IRQTM_EXTERNAL_CLOCK_ENABLE];  // see RL8
  assign external_trigger_enable_out = timing_r[`IRQTM_EXT_TRIG];  // see RL8
  assign overrange_disable_out = measurement_control_r[`IRQTM_OVR_DIS];
  assign low_noise_out = measurement_control_r[`IRQTM_LOW_NOISE];  // see RL15
  assign bandwidth_sel_out = measurement_control_r[`IRQTM_BW_MSB:`IRQTM_BW_LSB];
  assign bandwidth_hz_out = bw_hz_r;
  assign activity_detect_enable_out = act_en_r;
  assign inactivity_detect_enable_out = inact_en_r;
  assign activity_flag_out = act_flag_r;
  assign inactivity_flag_out = inact_flag_r;
  assign wake_mode_enter_out = wake_enter_r;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);

  property p_rate_top;
    (sample_rate_sel_out == 3'h4) ##1 (sample_rate_sel_out == 3'h4)
      |-> sample_rate_hz_out == 13'h1400;
  endproperty
  a_rate_top: assert property (p_rate_top) else $error("rate code 4 not 5120 Hz"); // see RL6

  property p_wake_top;
    (wake_interval_sel_out == 3'h7) ##1 (wake_interval_sel_out == 3'h7)
      |-> wake_period_ms_out == 15'h7800;
  endproperty
  a_wake_top: assert property (p_wake_top) else $error("wake code 7 not 30720 ms"); // see RL7

  property p_no_autosleep;
    !(seq_field inside {`IRQTM_SEQ_LINKED, `IRQTM_SEQ_LOOPED}) |=> !wake_mode_enter_out;
  endproperty
  a_no_autosleep: assert property (p_no_autosleep) else $error("autosleep in default"); // see RL10

  property p_autosleep;
    measurement_control_r[`IRQTM_AUTOSLEEP] && (seq_field inside {`IRQTM_SEQ_LINKED, `IRQTM_SEQ_LOOPED})
      && (&axis_activity_enable_in) && (&axis_inactivity_enable_in)
      && cond_in.inactivity && inactivity_detect_enable_out |=> wake_mode_enter_out;
  endproperty
  a_autosleep: assert property (p_autosleep) else $error("autosleep missed"); // see RL9

  property p_concurrent;
    !sequenced |=> activity_detect_enable_out && inactivity_detect_enable_out;
  endproperty
  a_concurrent: assert property (p_concurrent) else $error("default not concurrent"); // see RL11

  property p_one_at_time;
    sequenced |=> activity_detect_enable_out != inactivity_detect_enable_out;
  endproperty
  a_one_at_time: assert property (p_one_at_time) else $error("both detectors on"); // see RL12

  property p_loop_ack;
    looped && act_flag_r && !act_hit |=> !activity_flag_out;
  endproperty
  a_loop_ack: assert property (p_loop_ack) else $error("looped flag not cleared"); // see RL13

  property p_reserved_read;
    reg_req_in.rd && (reg_req_in.addr == `IRQTM_ADDR_ROUTE) |=> reg_rdata_out[3:1] == 3'h0;
  endproperty
  a_reserved_read: assert property (p_reserved_read) else $error("reserved bits set"); // see RL20

  property p_act_on_pin;
    route_r[`IRQTM_ROUTE_ACT] && act_flag_r |=> irq_pin_b_out != $past(route_r[7]);
  endproperty
  a_act_on_pin: assert property (p_act_on_pin) else $error("activity not on pin"); // see RL3

  property p_route_write;
    reg_req_in.wr && (reg_req_in.addr == `IRQTM_ADDR_ROUTE)
      |=> route_r == ($past(reg_req_in.wdata) & `IRQTM_ROUTE_WMASK);
  endproperty
  a_route_write: assert property (p_route_write) else $error("routing write wrong"); // see RL20

  property p_bw_top;
    (bandwidth_sel_out == 3'h4) ##1 (bandwidth_sel_out == 3'h4)
      |-> bandwidth_hz_out == 12'hA00;
  endproperty
  a_bw_top: assert property (p_bw_top) else $error("bandwidth code 4 not 2560 Hz"); // see RL16

  property p_external_trigger_enable;
    reg_req_in.wr && (reg_req_in.addr == `IRQTM_ADDR_TIMING)
      |=> {external_clock_enable_out, external_trigger_enable_out} == $past(reg_req_in.wdata[1:0]);
  endproperty
  a_external_trigger_enable: assert property (p_external_trigger_enable) else $error("external enables wrong"); // see RL8

  property p_low_noise;
    reg_req_in.wr && (reg_req_in.addr == `IRQTM_ADDR_MEASUREMENT_CONTROL)
      |=> low_noise_out == $past(reg_req_in.wdata[3]);
  endproperty
  a_low_noise: assert property (p_low_noise) else $error("low noise bit wrong"); // see RL15

  property p_act_set_wins;
    act_hit |=> activity_flag_out;
  endproperty
  a_act_set_wins: assert property (p_act_set_wins) else $error("activity event lost"); // see RL11

  property p_inact_set_wins;
    inact_hit |=> inactivity_flag_out;
  endproperty
  a_inact_set_wins: assert property (p_inact_set_wins) else $error("inactivity event lost"); // see RL11

  property p_linked_hold;
    (seq_mode == `IRQTM_SEQ_LINKED) && act_flag_r && !status_read_in |=> activity_flag_out;
  endproperty
  a_linked_hold: assert property (p_linked_hold) else $error("linked flag lost"); // see RL12

  c_linked_swap: cover property (sequenced && act_hit ##1 inactivity_detect_enable_out);
  c_autosleep: cover property (wake_mode_enter_out);
  c_sticky_ack: cover property (activity_flag_out ##1 status_read_in ##1 !activity_flag_out);

endmodule
`default_nettype wire
